// ---- rtl/iec_pkg.sv ----
// Package: register map, field positions and shared types of the interrupt enable block
package iec_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFF_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_ENABLE0   = 8'h04;
  localparam logic [7:0] OFF_ENABLE1   = 8'h08;
  localparam logic [7:0] OFF_ENABLE2   = 8'h0C;
  localparam logic [7:0] OFF_FLAGS0    = 8'h10;
  localparam logic [7:0] OFF_FLAGS1    = 8'h14;
  localparam logic [7:0] OFF_FLAGS2    = 8'h18;
  localparam logic [7:0] OFF_PINSEL    = 8'h1C;
  localparam logic [7:0] OFF_EVSTAT    = 8'h20;
  localparam logic [7:0] OFF_EVMASK    = 8'h24;

  // Control register fields
  localparam int BIT_GLOBAL_EN   = 7;
  localparam int BIT_PERIPH_EN   = 6;
  localparam int BIT_EDGE_SEL    = 0;
  localparam logic [7:0] CONTROL_MASK = 8'hC1;
  localparam logic [7:0] CONTROL_RST  = 8'h01;

  // Enable register zero fields
  localparam int BIT_TIMER0_OVF  = 5;
  localparam int BIT_PIN_CHANGE  = 4;
  localparam int BIT_EXT_PIN     = 0;
  localparam logic [7:0] ENABLE0_MASK = 8'h31;
  localparam logic [7:0] ENABLE_RST   = 8'h00;

  // Enable register two fields named separately
  localparam int BIT_MEMORY_TASK  = 4;
  localparam int BIT_OSC_ROLLOVER = 0;

  // Side event status bits
  localparam int EV_VECTOR   = 0;
  localparam int EV_RETURN   = 1;
  localparam int EV_EXT_EDGE = 2;
  localparam int EV_WIDTH    = 3;

  // Program vector for a taken request
  localparam logic [15:0] IRQ_VECTOR = 16'h0004;

  // Source requests grouped by enable register
  typedef struct packed {
    logic [7:0] group0;
    logic [7:0] group1;
    logic [7:0] group2;
  } iec_src_s;

  // Core handshake carrier
  typedef struct packed {
    logic accept;
    logic ret;
  } iec_core_s;

endpackage

// ---- rtl/iec_edge_detect.sv ----
// Edge detector for the selected external interrupt pin
`timescale 1ns/100ps
module iec_edge_detect #(
  parameter int PINS = 8
) (
  input  wire logic                    clk_in,
  input  wire logic                    reset_in,
  input  wire logic [PINS-1:0]         pins_in,
  input  wire logic [$clog2(PINS)-1:0] sel_in,
  input  wire logic                    rising_in,
  output logic                         edge_out
);

  // Elaboration check: a one-pin select would have a zero-width index
  if (PINS < 2) begin : g_pins_check
    $error("PINS must be at least 2");
  end

  logic pin_now;
  logic pin_reg;
  logic primed_reg;

  // Pin picked by the pin-select setting, never a fixed pin
  assign pin_now = pins_in[sel_in];

  // Previous level; primed stops a false edge right after reset
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_reg    <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      pin_reg    <= pin_now;
      primed_reg <= 1'b1;
    end
  end

  // Rising edge when select is one, falling when zero
  assign edge_out = primed_reg &
                    (rising_in ? (pin_now & ~pin_reg) : (~pin_now & pin_reg));

endmodule

// ---- rtl/iec_top.sv ----
// Interrupt enable and gating controller with APB register access
//
// Operation
// - Global enable one passes enabled sources; zero blocks every request to core.
// - Peripheral-group enable passes peripheral requests when set, suppresses when cleared.
// - Edge select one means rising external edge, zero means falling.
// - Unimplemented bits in control and enable zero always read zero.
// - Enable zero bit 5 gates the timer-zero overflow request.
// - Enable zero bit 4 gates the pin change-notification request.
// - Enable zero bit 0 gates the external-pin edge request.
// - External interrupt pin comes from the pin-select setting.
// - Enable one gates timer1 gate, converter, serial, sync port, timers.
// - Enable two gates timer6, comparators, memory, port two, timer4, oscillator.
// - Enable two bit 4 gates the memory task-complete request.
// - Enable two bit 0 gates the oscillator rollover request.
// - Source flags set on events regardless of any enable bits.
// - Accepted request clears global enable, unless a return arrives in the same cycle, and vectors the core to 0004h.
// - Return from interrupt sets global enable again.
// - External-pin flag sets on the selected edge of the pin.
`timescale 1ns/100ps
module iec_top #(
  parameter int PINS = 8
) (
  input  wire logic                    clk_in,
  input  wire logic                    reset_in,
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [7:0]              paddr_in,
  input  wire logic [31:0]             pwdata_in,
  output logic      [31:0]             prdata_out,
  output logic                         pready_out,
  output logic                         pslverr_out,
  input  wire iec_pkg::iec_src_s       src_event_in,
  input  wire logic [PINS-1:0]         ext_pins_in,
  input  wire iec_pkg::iec_core_s      core_in,
  output logic                         core_irq_out,
  output logic      [15:0]             vector_out,
  output logic                         irq_out
);

  // Elaboration check: the pin select must fit the low byte of a register
  if (PINS < 2 || PINS > 256) begin : g_pins_check
    $error("PINS must be 2 to 256");
  end

  localparam int SELW = $clog2(PINS);

  // Registers
  logic [7:0]          control_reg;
  logic [7:0]          enable0_reg;
  logic [7:0]          enable1_reg;
  logic [7:0]          enable2_reg;
  iec_pkg::iec_src_s   flags_reg;
  logic [SELW-1:0]     pinsel_reg;
  logic [iec_pkg::EV_WIDTH-1:0] evstat_reg;
  logic [iec_pkg::EV_WIDTH-1:0] evmask_reg;
  logic [31:0]         prdata_reg;
  logic [15:0]         vector_reg;

  // Bus decode
  logic wr_en;
  logic rd_en;
  logic hit_control;
  logic hit_enable0;
  logic hit_enable1;
  logic hit_enable2;
  logic hit_flags0;
  logic hit_flags1;
  logic hit_flags2;
  logic hit_pinsel;
  logic hit_evstat;
  logic hit_evmask;
  logic hit_any;
  logic [7:0] wbyte;

  // Single-cycle access phase, so pready stays high
  assign pready_out  = 1'b1;
  assign wr_en       = psel_in & penable_in & pwrite_in;
  assign rd_en       = psel_in & ~penable_in & ~pwrite_in; // Setup cycle of a read
  assign wbyte       = pwdata_in[7:0];
  assign hit_control = (paddr_in == iec_pkg::OFF_CONTROL);
  assign hit_enable0 = (paddr_in == iec_pkg::OFF_ENABLE0);
  assign hit_enable1 = (paddr_in == iec_pkg::OFF_ENABLE1);
  assign hit_enable2 = (paddr_in == iec_pkg::OFF_ENABLE2);
  assign hit_flags0  = (paddr_in == iec_pkg::OFF_FLAGS0);
  assign hit_flags1  = (paddr_in == iec_pkg::OFF_FLAGS1);
  assign hit_flags2  = (paddr_in == iec_pkg::OFF_FLAGS2);
  assign hit_pinsel  = (paddr_in == iec_pkg::OFF_PINSEL);
  assign hit_evstat  = (paddr_in == iec_pkg::OFF_EVSTAT);
  assign hit_evmask  = (paddr_in == iec_pkg::OFF_EVMASK);
  assign hit_any     = hit_control | hit_enable0 | hit_enable1 | hit_enable2 |
                       hit_flags0 | hit_flags1 | hit_flags2 | hit_pinsel |
                       hit_evstat | hit_evmask;
  // Unmapped addresses answer with an error, no state changes
  assign pslverr_out = psel_in & penable_in & ~hit_any;

  // Control fields
  logic global_irq_en;
  logic periph_group_irq_en;
  logic ext_pin_edge_sel;
  assign global_irq_en       = control_reg[iec_pkg::BIT_GLOBAL_EN];
  assign periph_group_irq_en = control_reg[iec_pkg::BIT_PERIPH_EN];
  assign ext_pin_edge_sel    = control_reg[iec_pkg::BIT_EDGE_SEL];

  // External pin edge from the selected pin
  logic ext_edge;
  iec_edge_detect #(
    .PINS(PINS)
  ) u_edge (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .pins_in  (ext_pins_in),
    .sel_in   (pinsel_reg),
    .rising_in(ext_pin_edge_sel),
    .edge_out (ext_edge)
  );

  // Group zero events: the external edge replaces the bit 0 input
  iec_pkg::iec_src_s events;
  always_comb begin
    events = src_event_in;
    events.group0 = src_event_in.group0 & iec_pkg::ENABLE0_MASK;
    events.group0[iec_pkg::BIT_EXT_PIN] = ext_edge;
  end

  // Flags: set wins over a software clear written as one
  iec_pkg::iec_src_s flags_next;
  always_comb begin
    flags_next = flags_reg;
    if (wr_en && hit_flags0) flags_next.group0 = flags_reg.group0 & ~wbyte;
    if (wr_en && hit_flags1) flags_next.group1 = flags_reg.group1 & ~wbyte;
    if (wr_en && hit_flags2) flags_next.group2 = flags_reg.group2 & ~wbyte;
    flags_next = flags_next | events;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) flags_reg <= '0;
    else flags_reg <= flags_next;
  end

  // Gated requests per group
  logic [7:0] pend0;
  logic [7:0] pend1;
  logic [7:0] pend2;
  logic       periph_req;
  assign pend0 = flags_reg.group0 & enable0_reg;
  assign pend1 = flags_reg.group1 & enable1_reg;
  assign pend2 = flags_reg.group2 & enable2_reg;
  assign periph_req = periph_group_irq_en & (|{pend1, pend2});
  // Pending flags are held, so a request resumes once global enable returns
  assign core_irq_out = global_irq_en & ((|pend0) | periph_req);

  // Accept only counts while a request is offered
  logic take;
  assign take = core_in.accept & core_irq_out;

  // Control register: hardware clear on accept, set on return
  logic [7:0] control_next;
  always_comb begin
    control_next = control_reg;
    if (wr_en && hit_control) control_next = wbyte & iec_pkg::CONTROL_MASK;
    if (take) control_next[iec_pkg::BIT_GLOBAL_EN] = 1'b0;
    if (core_in.ret) control_next[iec_pkg::BIT_GLOBAL_EN] = 1'b1;
  end

  // Enables and control reset per reset values
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      control_reg <= iec_pkg::CONTROL_RST;
      enable0_reg <= iec_pkg::ENABLE_RST;
      enable1_reg <= iec_pkg::ENABLE_RST;
      enable2_reg <= iec_pkg::ENABLE_RST;
      pinsel_reg  <= '0;
    end else begin
      control_reg <= control_next;
      if (wr_en && hit_enable0) enable0_reg <= wbyte & iec_pkg::ENABLE0_MASK;
      if (wr_en && hit_enable1) enable1_reg <= wbyte;
      if (wr_en && hit_enable2) enable2_reg <= wbyte;
      if (wr_en && hit_pinsel) pinsel_reg <= pwdata_in[SELW-1:0];
    end
  end

  // Vector output is loaded on accept
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) vector_reg <= 16'h0000;
    else if (take) vector_reg <= iec_pkg::IRQ_VECTOR;
  end
  assign vector_out = vector_reg;

  // Side events: sticky status, write one to clear, set wins
  logic [iec_pkg::EV_WIDTH-1:0] ev_now;
  logic [iec_pkg::EV_WIDTH-1:0] evstat_next;
  assign ev_now = {ext_edge, core_in.ret, take};
  always_comb begin
    evstat_next = evstat_reg;
    if (wr_en && hit_evstat) evstat_next = evstat_reg & ~wbyte[iec_pkg::EV_WIDTH-1:0];
    evstat_next = evstat_next | ev_now;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      evstat_reg <= '0;
      evmask_reg <= '0;
    end else begin
      evstat_reg <= evstat_next;
      if (wr_en && hit_evmask) evmask_reg <= wbyte[iec_pkg::EV_WIDTH-1:0];
    end
  end
  assign irq_out = |(evstat_reg & evmask_reg);

  // Read mux; narrow registers sit in the low bits
  logic [7:0] rd_byte;
  assign rd_byte = hit_control ? control_reg :
                   hit_enable0 ? enable0_reg :
                   hit_enable1 ? enable1_reg :
                   hit_enable2 ? enable2_reg :
                   hit_flags0  ? flags_reg.group0 :
                   hit_flags1  ? flags_reg.group1 :
                   hit_flags2  ? flags_reg.group2 :
                   hit_pinsel  ? 8'(pinsel_reg) :
                   hit_evstat  ? 8'(evstat_reg) :
                   hit_evmask  ? 8'(evmask_reg) : 8'h00;

  // Read data captured at the end of setup, so it stands through the access phase
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) prdata_reg <= 32'h0000_0000;
    else if (rd_en) prdata_reg <= {24'h00_0000, rd_byte};
  end
  assign prdata_out = prdata_reg;

  // Checks
  a_unimpl_zero: assert property (@(posedge clk_in) disable iff (reset_in)
    ((control_reg & ~iec_pkg::CONTROL_MASK) == 8'h00) &&
    ((enable0_reg & ~iec_pkg::ENABLE0_MASK) == 8'h00))
    else $error("Unimplemented bits not zero");

  a_global_blocks: assert property (@(posedge clk_in) disable iff (reset_in)
    !global_irq_en |-> !core_irq_out)
    else $error("Request passed with global enable clear");

  a_periph_blocks: assert property (@(posedge clk_in) disable iff (reset_in)
    (!periph_group_irq_en && pend0 == 8'h00) |-> !core_irq_out)
    else $error("Peripheral request passed with group enable clear");

  a_accept_clears: assert property (@(posedge clk_in) disable iff (reset_in)
    (take && !core_in.ret) |=> (!global_irq_en && vector_out == 16'h0004))
    else $error("Accept did not clear enable and vector");

  a_return_sets: assert property (@(posedge clk_in) disable iff (reset_in)
    core_in.ret |=> global_irq_en)
    else $error("Return did not set global enable");

  a_flag_sticks: assert property (@(posedge clk_in) disable iff (reset_in)
    (src_event_in.group1 != 8'h00) |=> ((flags_reg.group1 & $past(src_event_in.group1))
      == $past(src_event_in.group1)))
    else $error("Flag not set by event");

  a_ext_edge_flag: assert property (@(posedge clk_in) disable iff (reset_in)
    ext_edge |=> flags_reg.group0[iec_pkg::BIT_EXT_PIN])
    else $error("External edge did not set its flag");

  a_mem_gate: assert property (@(posedge clk_in) disable iff (reset_in)
    (global_irq_en && periph_group_irq_en && enable2_reg[iec_pkg::BIT_MEMORY_TASK] &&
     flags_reg.group2[iec_pkg::BIT_MEMORY_TASK]) |-> core_irq_out)
    else $error("Memory task request not passed");

  a_osc_gate: assert property (@(posedge clk_in) disable iff (reset_in)
    (global_irq_en && periph_group_irq_en && enable2_reg[iec_pkg::BIT_OSC_ROLLOVER] &&
     flags_reg.group2[iec_pkg::BIT_OSC_ROLLOVER]) |-> core_irq_out)
    else $error("Oscillator rollover request not passed");

  a_timer0_gate: assert property (@(posedge clk_in) disable iff (reset_in)
    (global_irq_en && enable0_reg[iec_pkg::BIT_TIMER0_OVF] &&
     flags_reg.group0[iec_pkg::BIT_TIMER0_OVF]) |-> core_irq_out)
    else $error("Timer zero request not passed");

endmodule

// ---- dv/iec_core_model.sv ----
// Behavioural processor core that takes requests and returns from service
`timescale 1ns/100ps
module iec_core_model (
  input  wire logic          clk_in,
  input  wire logic          reset_in,
  input  wire logic          irq_in,
  input  wire logic          take_en_in,
  input  wire logic [3:0]    delay_in,
  input  wire logic          ret_req_in,
  output iec_pkg::iec_core_s core_out
);
  logic [3:0] wait_reg;

  // Accept a standing request after delay_in cycles; a slow core lets events pile up
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      core_out <= '0;
      wait_reg <= 4'h0;
    end else begin
      core_out.ret <= ret_req_in;
      core_out.accept <= 1'b0;
      if (take_en_in && irq_in && !core_out.accept) begin
        wait_reg <= (wait_reg == delay_in) ? 4'h0 : wait_reg + 4'h1;
        if (wait_reg == delay_in) begin
          core_out.accept <= 1'b1;  // One pulse, never two for one request
        end
      end else begin
        wait_reg <= 4'h0;
      end
    end
  end
endmodule

// ---- dv/tb_top.sv ----
// Self-checking testbench of the interrupt enable block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  logic               clk_in, reset_in, psel, penable, pwrite, pready, pslverr;
  logic               core_irq, irq, take_en, ret_req;
  logic [7:0]         paddr, pins;
  logic [31:0]        pwdata, prdata;
  logic [15:0]        vector;
  logic [3:0]         delay;
  iec_pkg::iec_src_s  src;
  iec_pkg::iec_core_s core;
  int                 err_count, n_checks;

  iec_top #(.PINS(8)) iec_top_i (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .src_event_in(src),
    .ext_pins_in(pins), .core_in(core), .core_irq_out(core_irq), .vector_out(vector),
    .irq_out(irq));
  iec_core_model iec_core_model_i (.clk_in(clk_in), .reset_in(reset_in), .irq_in(core_irq),
    .take_en_in(take_en), .delay_in(delay), .ret_req_in(ret_req), .core_out(core));

  // One APB transfer; waits for pready, so no slave latency is assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    // Answer taken at the edge where pready is seen high, then released
    e = pslverr;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, {24'h00_0000, d}, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x, input string nm);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    `CHK(nm, {24'h00_0000, x}, q)
  endtask

  // Events are single-cycle pulses; outputs are settled when this returns
  task automatic pulse(input logic [23:0] v);
    @(posedge clk_in);
    src <= iec_pkg::iec_src_s'(v);
    @(posedge clk_in);
    src <= '0;
    #1;
  endtask

  task automatic pins_to(input logic [7:0] v);
    @(posedge clk_in);
    pins <= v;
    repeat (4) @(posedge clk_in);
  endtask

  task automatic clr();
    wr(iec_pkg::OFF_FLAGS0, 8'hFF);
    wr(iec_pkg::OFF_FLAGS1, 8'hFF);
    wr(iec_pkg::OFF_FLAGS2, 8'hFF);
  endtask

  task automatic t_reset();
    rd(iec_pkg::OFF_CONTROL, 8'h01, "control");
    rd(iec_pkg::OFF_ENABLE0, 8'h00, "enable0");
    rd(iec_pkg::OFF_ENABLE1, 8'h00, "enable1");
    rd(iec_pkg::OFF_ENABLE2, 8'h00, "enable2");
    `CHK("core req", 1'b0, core_irq)
    `CHK("vector", 16'h0000, vector)
    `CHK("pready", 1'b1, pready)
    $display("test reset values finished");
  endtask

  // Reserved bits drop writes; unmapped address is refused
  task automatic t_reserved();
    logic [31:0] q;
    logic        e;
    wr(iec_pkg::OFF_CONTROL, 8'h7E);
    rd(iec_pkg::OFF_CONTROL, 8'h40, "control rsv");
    wr(iec_pkg::OFF_ENABLE0, 8'hFF);
    rd(iec_pkg::OFF_ENABLE0, 8'h31, "enable0 rsv");
    wr(iec_pkg::OFF_ENABLE1, 8'hA5);
    rd(iec_pkg::OFF_ENABLE1, 8'hA5, "enable1 rw");
    wr(iec_pkg::OFF_ENABLE2, 8'h5A);
    rd(iec_pkg::OFF_ENABLE2, 8'h5A, "enable2 rw");
    apb(1'b0, 8'h40, 32'h0000_0000, q, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0000_0000, q)
    wr(iec_pkg::OFF_CONTROL, 8'h01);
    wr(iec_pkg::OFF_ENABLE0, 8'h00);
    wr(iec_pkg::OFF_ENABLE1, 8'h00);
    wr(iec_pkg::OFF_ENABLE2, 8'h00);
    $display("test reserved bits finished");
  endtask

  // Flags set with global enable clear; then each gate level in turn
  task automatic t_gates();
    wr(iec_pkg::OFF_CONTROL, 8'h40);
    wr(iec_pkg::OFF_ENABLE1, 8'h01);
    pulse(24'hFF_FFFF);
    `CHK("req no global", 1'b0, core_irq)
    rd(iec_pkg::OFF_FLAGS0, 8'h30, "flags0");
    rd(iec_pkg::OFF_FLAGS1, 8'hFF, "flags1");
    rd(iec_pkg::OFF_FLAGS2, 8'hFF, "flags2");
    wr(iec_pkg::OFF_CONTROL, 8'h80);
    `CHK("req no periph", 1'b0, core_irq)
    wr(iec_pkg::OFF_CONTROL, 8'hC0);
    `CHK("req both", 1'b1, core_irq)
    wr(iec_pkg::OFF_ENABLE1, 8'h00);
    wr(iec_pkg::OFF_ENABLE0, 8'h20);
    wr(iec_pkg::OFF_CONTROL, 8'h80);
    `CHK("group0 no periph", 1'b1, core_irq)
    wr(iec_pkg::OFF_ENABLE0, 8'h00);
    clr();
    $display("test global gating finished");
  endtask

  // Every source bit but the external pin: others do not pass, own one does, clearing its enable blocks it
  task automatic t_sources();
    int          i;
    logic [7:0]  a;
    logic [23:0] m;
    wr(iec_pkg::OFF_CONTROL, 8'hC0);
    for (i = 0; i < 24; i++) begin
      if (i >= 16 && i != 20 && i != 21) continue;
      m = 24'h00_0001 << i;
      a = 8'h04 + 8'((2 - i / 8) * 4);
      wr(a, 8'(1 << (i % 8)));
      pulse(~m);
      `CHK("req others", 1'b0, core_irq)
      pulse(m);
      `CHK("req own", 1'b1, core_irq)
      wr(a, 8'h00);
      `CHK("req gated", 1'b0, core_irq)
      clr();
    end
    $display("test source gates finished");
  endtask

  // Selected pin only, on the selected edge
  task automatic t_ext();
    wr(iec_pkg::OFF_CONTROL, 8'h01);
    wr(iec_pkg::OFF_PINSEL, 8'h03);
    wr(iec_pkg::OFF_ENABLE0, 8'h01);
    pins_to(8'h20);
    pins_to(8'h00);
    rd(iec_pkg::OFF_FLAGS0, 8'h00, "other pin");
    pins_to(8'h08);
    rd(iec_pkg::OFF_FLAGS0, 8'h01, "rising edge");
    clr();
    pins_to(8'h00);
    rd(iec_pkg::OFF_FLAGS0, 8'h00, "falling ignored");
    wr(iec_pkg::OFF_CONTROL, 8'h00);
    pins_to(8'h08);
    rd(iec_pkg::OFF_FLAGS0, 8'h00, "rising ignored");
    pins_to(8'h00);
    rd(iec_pkg::OFF_FLAGS0, 8'h01, "falling edge");
    wr(iec_pkg::OFF_CONTROL, 8'h80);
    `CHK("ext req", 1'b1, core_irq)
    wr(iec_pkg::OFF_ENABLE0, 8'h00);
    `CHK("ext gated", 1'b0, core_irq)
    clr();
    $display("test external pin finished");
  endtask

  // Core takes a request, then returns; side status and its mask drive irq
  task automatic t_service();
    int k;
    // Pin edges of the earlier test left their sticky status bit set
    wr(iec_pkg::OFF_EVSTAT, 8'h07);
    wr(iec_pkg::OFF_EVMASK, 8'h01);
    wr(iec_pkg::OFF_ENABLE2, 8'h10);
    wr(iec_pkg::OFF_CONTROL, 8'hC1);
    @(posedge clk_in);
    take_en <= 1'b1;
    pulse(24'h00_0010);
    for (k = 0; k < 20 && core_irq !== 1'b0; k++) @(posedge clk_in);
    #1;
    `CHK("vector", 16'h0004, vector)
    `CHK("irq accept", 1'b1, irq)
    @(posedge clk_in);
    take_en <= 1'b0;
    rd(iec_pkg::OFF_CONTROL, 8'h41, "global cleared");
    clr();
    @(posedge clk_in);
    ret_req <= 1'b1;
    @(posedge clk_in);
    ret_req <= 1'b0;
    repeat (2) @(posedge clk_in);
    rd(iec_pkg::OFF_CONTROL, 8'hC1, "global restored");
    rd(iec_pkg::OFF_EVSTAT, 8'h03, "event status");
    wr(iec_pkg::OFF_EVSTAT, 8'h01);
    `CHK("irq masked", 1'b0, irq)
    rd(iec_pkg::OFF_EVSTAT, 8'h02, "status w1c");
    $display("test core service finished");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Clock of 5 ns
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // The whole run takes well under a thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    $display("BAD watchdog exp finish got timeout");
    wrap_up();
  end

  initial begin
    {psel, penable, pwrite, take_en, ret_req} = '0;
    {paddr, pins, pwdata, delay} = '0;
    src = '0;
    err_count = 0;
    n_checks = 0;
    reset_in = 1'b1;
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    delay = 4'h3;
    t_reset();
    t_reserved();
    t_gates();
    t_sources();
    t_ext();
    t_service();
    wrap_up();
  end
endmodule
